// *** common/lcd_regs_pkg.sv ***
// Register map, field layout and reset values for the background, resolution and palette registers
package lcd_regs_pkg;
  // Byte offsets on the register bus
  localparam logic [11:0] BG_COLOUR_OFFSET = 12'h000;
  localparam logic [11:0] RESOLUTION_OFFSET = 12'h004;
  localparam logic [11:0] PALETTE_BASE = 12'h400;
  localparam int PALETTE_ENTRIES = 256;
  localparam int PALETTE_IDX_W = 8;
  // Field positions
  localparam int RED_LSB = 24;
  localparam int GREEN_LSB = 16;
  localparam int BLUE_LSB = 8;
  localparam int ALPHA_LSB = 0;
  localparam int HPIX_LSB = 16;
  localparam int VPIX_LSB = 0;
  localparam int RES_W = 11;
  localparam int PAL_RED_LSB = 16;
  localparam int PAL_GREEN_LSB = 8;
  localparam int PAL_BLUE_LSB = 0;
  // Reset values
  localparam logic [31:0] BG_COLOUR_RESET = 32'h0000_0000;
  localparam logic [10:0] RES_RESET = 11'h000;
  localparam logic [23:0] PALETTE_RESET = 24'h00_0000;
  // Writable masks
  localparam logic [31:0] RESOLUTION_MASK = 32'h07ff_07ff;
  localparam logic [31:0] PALETTE_MASK = 32'h00ff_ffff;
endpackage : lcd_regs_pkg

// *** src/palette_store.sv ***
// Palette lookup table storage: 256 entries of 24-bit RGB
`timescale 1ns/1ps
module palette_store
  import lcd_regs_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Write port
  input wire logic i_wr_en,
  input wire logic [7:0] i_wr_idx,
  input wire logic [23:0] i_wr_data,
  // Read ports: software side and pixel side
  input wire logic [7:0] i_rd_idx,
  output logic [23:0] o_rd_data,
  input wire logic [7:0] i_pix_idx,
  output logic [23:0] o_pix_rgb
);
  logic [23:0] entry_ff [PALETTE_ENTRIES];

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      for (int k = 0; k < PALETTE_ENTRIES; k++) begin
        entry_ff[k] <= PALETTE_RESET;
      end
    end else if (i_wr_en) begin
      entry_ff[i_wr_idx] <= i_wr_data;
    end
  end

  assign o_rd_data = entry_ff[i_rd_idx];

  // Pixel lookup registered so the colour output comes from a flip-flop
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_pix_rgb <= PALETTE_RESET;
    end else begin
      o_pix_rgb <= entry_ff[i_pix_idx];
    end
  end
endmodule : palette_store

// *** src/lcd_bg_res_palette_regs.sv ***
// APB register bank holding background colour, display resolution and palette
// Behaviour
// - A 32-bit background colour holds red 31-24, green 23-16, blue 15-8, alpha 7-0 and drives the background output.
// - An all-ones background register gives full red, green, blue and alpha as the background colour.
// - Bits 26-16 of the resolution register are a writable 11-bit horizontal pixel count.
// - Bits 10-0 of the resolution register are a writable 11-bit vertical pixel count.
// - Two hundred fifty-six palette entries, index 0 to 255, each hold red 23-16, green 15-8, blue 7-0.
// - Resolution bits 31-27 and 15-11 and palette bits 31-24 always read as zero.
//
// Our own choices: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
module lcd_bg_res_palette_regs
  import lcd_regs_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // APB slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [3:0] i_pstrb,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // Settings to pixel and timing logic
  output logic [7:0] o_bg_red,
  output logic [7:0] o_bg_green,
  output logic [7:0] o_bg_blue,
  output logic [7:0] o_bg_alpha,
  output logic [10:0] o_horizontal_pixels,
  output logic [10:0] o_vertical_pixels,
  // Palette lookup from the pixel path, result one cycle later
  input wire logic [7:0] i_pix_idx,
  output logic [23:0] o_pix_rgb
);
  logic [31:0] background_colour_ff;
  logic [10:0] hpix_ff;
  logic [10:0] vpix_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic [31:0] prdata_ff;
  logic [23:0] pal_rd_data;

  // Address decode
  wire access_phase = i_psel && i_penable && !pready_ff;
  wire hit_bg = (i_paddr == BG_COLOUR_OFFSET);
  wire hit_res = (i_paddr == RESOLUTION_OFFSET);
  wire hit_pal = (i_paddr[11:10] == PALETTE_BASE[11:10]) && (i_paddr[1:0] == 2'b00);
  wire hit_any = hit_bg || hit_res || hit_pal;
  wire wr_ok = access_phase && i_pwrite && hit_any;
  wire [7:0] pal_idx = i_paddr[9:2];

  function automatic logic [31:0] merge_bytes(input logic [31:0] old_v, input logic [31:0] new_v,
                                              input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return r;
  endfunction : merge_bytes

  wire [31:0] res_now = {5'h00, hpix_ff, 5'h00, vpix_ff};
  wire [31:0] nxt_bg = merge_bytes(background_colour_ff, i_pwdata, i_pstrb);
  wire [31:0] nxt_res = merge_bytes(res_now, i_pwdata, i_pstrb) & RESOLUTION_MASK;
  wire [31:0] nxt_pal = merge_bytes({8'h00, pal_rd_data}, i_pwdata, i_pstrb) & PALETTE_MASK;

  // Unused bits read zero, last write reads back
  wire [31:0] rd_mux = hit_bg ? background_colour_ff :
                       hit_res ? res_now :
                       hit_pal ? {8'h00, pal_rd_data} : 32'h0000_0000;

  palette_store u_palette (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_wr_en(wr_ok && hit_pal),
    .i_wr_idx(pal_idx),
    .i_wr_data(nxt_pal[23:0]),
    .i_rd_idx(pal_idx),
    .o_rd_data(pal_rd_data),
    .i_pix_idx(i_pix_idx),
    .o_pix_rgb(o_pix_rgb)
  );

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      background_colour_ff <= BG_COLOUR_RESET;
    end else if (wr_ok && hit_bg) begin
      background_colour_ff <= nxt_bg;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      hpix_ff <= RES_RESET;
      vpix_ff <= RES_RESET;
    end else if (wr_ok && hit_res) begin
      hpix_ff <= nxt_res[HPIX_LSB +: RES_W];
      vpix_ff <= nxt_res[VPIX_LSB +: RES_W];
    end
  end

  // APB answer one cycle into the access phase; unmapped gives pslverr
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
    end else begin
      pready_ff <= access_phase;
      pslverr_ff <= access_phase && !hit_any;
      prdata_ff <= (access_phase && !i_pwrite) ? rd_mux : 32'h0000_0000;
    end
  end

  // Output copies lag the registers by one cycle so every port leaves a flip-flop
  wire [31:0] nxt_out_bg = background_colour_ff;

  // Background bytes passed out as stored
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_bg_red <= BG_COLOUR_RESET[RED_LSB +: 8];
      o_bg_green <= BG_COLOUR_RESET[GREEN_LSB +: 8];
      o_bg_blue <= BG_COLOUR_RESET[BLUE_LSB +: 8];
      o_bg_alpha <= BG_COLOUR_RESET[ALPHA_LSB +: 8];
    end else begin
      o_bg_red <= nxt_out_bg[RED_LSB +: 8];
      o_bg_green <= nxt_out_bg[GREEN_LSB +: 8];
      o_bg_blue <= nxt_out_bg[BLUE_LSB +: 8];
      o_bg_alpha <= nxt_out_bg[ALPHA_LSB +: 8];
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_horizontal_pixels <= RES_RESET;
      o_vertical_pixels <= RES_RESET;
    end else begin
      o_horizontal_pixels <= hpix_ff;
      o_vertical_pixels <= vpix_ff;
    end
  end

  assign o_prdata = prdata_ff;
  assign o_pready = pready_ff;
  assign o_pslverr = pslverr_ff;

  // Assertions
  // Background write lands
  a_bg_write_lands: assert property (@(posedge i_clk) disable iff (i_rst)
    (wr_ok && hit_bg && i_pstrb == 4'hf) |=> background_colour_ff == $past(i_pwdata))
    else $error("background write not stored");

  a_bg_strobe_keep: assert property (@(posedge i_clk) disable iff (i_rst)
    (wr_ok && hit_bg && !i_pstrb[3]) |=> background_colour_ff[31:24] == $past(background_colour_ff[31:24]))
    else $error("background byte changed with strobe low");

  a_bg_out_follow: assert property (@(posedge i_clk) disable iff (i_rst)
    1'b1 |=> {o_bg_red, o_bg_green, o_bg_blue, o_bg_alpha} == $past(background_colour_ff))
    else $error("background output does not follow register");

  a_bg_full_ones: assert property (@(posedge i_clk) disable iff (i_rst)
    (background_colour_ff == 32'hffff_ffff) |=> (o_bg_red == 8'hff && o_bg_alpha == 8'hff))
    else $error("all ones background not passed out");

  a_hpix_write: assert property (@(posedge i_clk) disable iff (i_rst)
    (wr_ok && hit_res && i_pstrb == 4'hf) |=> hpix_ff == $past(i_pwdata[26:16]))
    else $error("horizontal field wrong");

  a_res_out_follow: assert property (@(posedge i_clk) disable iff (i_rst)
    1'b1 |=> (o_horizontal_pixels == $past(hpix_ff) && o_vertical_pixels == $past(vpix_ff)))
    else $error("resolution output does not follow register");

  a_vpix_write: assert property (@(posedge i_clk) disable iff (i_rst)
    (wr_ok && hit_res && i_pstrb == 4'hf) |=> ##1 o_vertical_pixels == $past(i_pwdata[10:0], 2))
    else $error("vertical field wrong");

  a_pal_write: assert property (@(posedge i_clk) disable iff (i_rst)
    (wr_ok && hit_pal && i_pstrb == 4'hf) |=> u_palette.entry_ff[$past(pal_idx)] == $past(i_pwdata[23:0]))
    else $error("palette entry not stored");

  a_pal_no_stray: assert property (@(posedge i_clk) disable iff (i_rst)
    (access_phase && !(i_pwrite && hit_pal)) |=>
      u_palette.entry_ff[$past(pal_idx)] == $past(u_palette.entry_ff[pal_idx]))
    else $error("palette entry changed without write");

  a_pix_lookup: assert property (@(posedge i_clk) disable iff (i_rst)
    1'b1 |=> o_pix_rgb == $past(u_palette.entry_ff[i_pix_idx]))
    else $error("pixel lookup wrong");

  a_res_zero_bits: assert property (@(posedge i_clk) disable iff (i_rst)
    (o_pready && $past(hit_res)) |-> (o_prdata[31:27] == 5'h00 && o_prdata[15:11] == 5'h00))
    else $error("resolution unused bits not zero");

  a_pal_zero_bits: assert property (@(posedge i_clk) disable iff (i_rst)
    (o_pready && $past(hit_pal)) |-> (o_prdata[31:24] == 8'h00))
    else $error("palette unused bits not zero");

  a_read_back: assert property (@(posedge i_clk) disable iff (i_rst)
    (access_phase && !i_pwrite && hit_bg) |=> (o_pready && o_prdata == $past(background_colour_ff)))
    else $error("read back mismatch");

  a_ready_pulse: assert property (@(posedge i_clk) disable iff (i_rst)
    o_pready |=> !o_pready)
    else $error("pready held too long");

  // Cover points
  c_bg_write: cover property (@(posedge i_clk) disable iff (i_rst) wr_ok && hit_bg);
  c_res_write: cover property (@(posedge i_clk) disable iff (i_rst) wr_ok && hit_res);
  c_pal_write: cover property (@(posedge i_clk) disable iff (i_rst) wr_ok && hit_pal);
  c_pal_read: cover property (@(posedge i_clk) disable iff (i_rst) access_phase && !i_pwrite && hit_pal);
  c_slverr: cover property (@(posedge i_clk) disable iff (i_rst) o_pslverr);
endmodule : lcd_bg_res_palette_regs

// *** verification/lcd_bg_res_palette_regs_tb.sv ***
// Self-checking APB testbench for the background, resolution and palette registers
`timescale 1ns/1ps
module lcd_bg_res_palette_regs_tb
  import lcd_regs_pkg::*;
;
  logic i_clk, i_rst, i_psel, i_penable, i_pwrite, o_pready, o_pslverr;
  logic [11:0] i_paddr;
  logic [31:0] i_pwdata, o_prdata;
  logic [3:0] i_pstrb;
  logic [7:0] o_bg_red, o_bg_green, o_bg_blue, o_bg_alpha, i_pix_idx;
  logic [10:0] o_horizontal_pixels, o_vertical_pixels;
  logic [23:0] o_pix_rgb, pal;
  int fails, cmp_count;

  lcd_bg_res_palette_regs uut (.i_clk(i_clk), .i_rst(i_rst), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .i_pstrb(i_pstrb), .o_prdata(o_prdata),
    .o_pready(o_pready), .o_pslverr(o_pslverr), .o_bg_red(o_bg_red), .o_bg_green(o_bg_green),
    .o_bg_blue(o_bg_blue), .o_bg_alpha(o_bg_alpha), .o_horizontal_pixels(o_horizontal_pixels),
    .o_vertical_pixels(o_vertical_pixels), .i_pix_idx(i_pix_idx), .o_pix_rgb(o_pix_rgb));

  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  task chk(input logic [31:0] act, input logic [31:0] exp);
    cmp_count++;
    if (act !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h want %h", $time, act, exp);
    end
  endtask : chk

  // One APB transfer; an idle edge first so no signal is assigned twice in a step
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
            input logic [31:0] xd, input logic xe);
    @(posedge i_clk);
    i_psel <= 1'b1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    i_pstrb <= s;
    @(posedge i_clk);
    i_penable <= 1'b1;
    // Wait for the answer however long it takes; only the watchdog ends a hang
    do begin
      @(posedge i_clk);
    end while (o_pready !== 1'b1);
    if (!w) chk(o_prdata, xd);
    chk({31'h0, o_pslverr}, {31'h0, xe});
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask : xfer

  task finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : finish_test

  // Palette sweep dominates run time; limit leaves ample margin
  initial begin
    #200000;
    fails++;
    finish_test();
  end

  initial begin
    i_rst <= 1'b1;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
    i_pwrite <= 1'b0;
    i_paddr <= 12'h000;
    i_pwdata <= 32'h0;
    i_pstrb <= 4'h0;
    i_pix_idx <= 8'h00;
    repeat (3) @(posedge i_clk);
    i_rst <= 1'b0;
    chk({o_bg_red, o_bg_green, o_bg_blue, o_bg_alpha}, BG_COLOUR_RESET);
    chk({10'h0, o_horizontal_pixels, o_vertical_pixels}, 32'h0);
    xfer(1'b0, BG_COLOUR_OFFSET, 32'h0, 4'hf, 32'h0, 1'b0);
    xfer(1'b0, RESOLUTION_OFFSET, 32'h0, 4'hf, 32'h0, 1'b0);
    xfer(1'b0, PALETTE_BASE + 12'h3fc, 32'h0, 4'hf, 32'h0, 1'b0);
    $display("reset values test done");
    xfer(1'b1, BG_COLOUR_OFFSET, 32'h1122_3344, 4'hf, 32'h0, 1'b0);
    xfer(1'b1, BG_COLOUR_OFFSET, 32'haabb_ccdd, 4'h5, 32'h0, 1'b0);
    xfer(1'b0, BG_COLOUR_OFFSET, 32'h0, 4'hf, 32'h11bb_33dd, 1'b0);
    repeat (2) @(posedge i_clk);
    chk({o_bg_red, o_bg_green, o_bg_blue, o_bg_alpha}, 32'h11bb_33dd);
    xfer(1'b1, BG_COLOUR_OFFSET, 32'hffff_ffff, 4'hf, 32'h0, 1'b0);
    repeat (2) @(posedge i_clk);
    chk({o_bg_red, o_bg_green, o_bg_blue, o_bg_alpha}, 32'hffff_ffff);
    $display("background test done");
    xfer(1'b1, RESOLUTION_OFFSET, 32'hffff_ffff, 4'hf, 32'h0, 1'b0);
    xfer(1'b0, RESOLUTION_OFFSET, 32'h0, 4'hf, 32'h07ff_07ff, 1'b0);
    repeat (2) @(posedge i_clk);
    chk({5'h0, o_horizontal_pixels, 5'h0, o_vertical_pixels}, 32'h07ff_07ff);
    xfer(1'b1, RESOLUTION_OFFSET, 32'hf555_a2aa, 4'hf, 32'h0, 1'b0);
    xfer(1'b0, RESOLUTION_OFFSET, 32'h0, 4'hf, 32'h0555_02aa, 1'b0);
    repeat (2) @(posedge i_clk);
    chk({5'h0, o_horizontal_pixels, 5'h0, o_vertical_pixels}, 32'h0555_02aa);
    $display("resolution test done");
    for (int i = 0; i < 256; i++) begin
      xfer(1'b1, PALETTE_BASE + 12'(4 * i), {8'hff, 8'(i), 8'(~i), 8'(i ^ 8'h5a)}, 4'hf, 32'h0, 1'b0);
    end
    for (int i = 0; i < 256; i++) begin
      pal = {8'(i), 8'(~i), 8'(i ^ 8'h5a)};
      i_pix_idx <= 8'(i);
      xfer(1'b0, PALETTE_BASE + 12'(4 * i), 32'h0, 4'hf, {8'h00, pal}, 1'b0);
      chk({8'h00, o_pix_rgb}, {8'h00, pal});
    end
    $display("palette test done");
    // Refused accesses must leave the background untouched
    xfer(1'b1, 12'h008, 32'h0, 4'hf, 32'h0, 1'b1);
    xfer(1'b0, 12'h008, 32'h0, 4'hf, 32'h0, 1'b1);
    xfer(1'b1, PALETTE_BASE + 12'h002, 32'h0, 4'hf, 32'h0, 1'b1);
    xfer(1'b0, PALETTE_BASE, 32'h0, 4'hf, 32'h0000_ff5a, 1'b0);
    xfer(1'b0, BG_COLOUR_OFFSET, 32'h0, 4'hf, 32'hffff_ffff, 1'b0);
    $display("unmapped test done");
    // Mid-run reset must clear the background, resolution and palette entry 255 fields and outputs
    i_rst <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_rst <= 1'b0;
    chk({o_bg_red, o_bg_green, o_bg_blue, o_bg_alpha}, BG_COLOUR_RESET);
    chk({10'h0, o_horizontal_pixels, o_vertical_pixels}, 32'h0);
    chk({8'h00, o_pix_rgb}, {8'h00, PALETTE_RESET});
    xfer(1'b0, BG_COLOUR_OFFSET, 32'h0, 4'hf, 32'h0, 1'b0);
    xfer(1'b0, RESOLUTION_OFFSET, 32'h0, 4'hf, 32'h0, 1'b0);
    xfer(1'b0, PALETTE_BASE + 12'h3fc, 32'h0, 4'hf, 32'h0, 1'b0);
    $display("mid-run reset test done");
    finish_test();
  end
endmodule : lcd_bg_res_palette_regs_tb
